/* kbd_pkg.sv */
// Shared constants and types of the keyboard matrix scanner
package kbd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Debounce window and bus instruction-cycle timing
  localparam int unsigned DEBOUNCE_NS = 11_000_000;
  localparam int unsigned BUS_PERIOD_NS = 1350;
  localparam int unsigned SLOTS_PER_CYCLE = 8;
  localparam int unsigned POSITIONS = 64;
  localparam int unsigned CONFIRM_PASSES = 5;
  // Instruction cycles per matrix position, rounded down and at least one
  localparam int unsigned STEP_RAW = DEBOUNCE_NS / (BUS_PERIOD_NS * SLOTS_PER_CYCLE) / (POSITIONS * (CONFIRM_PASSES - 1));
  localparam int unsigned STEP_CYCLES = (STEP_RAW < 1) ? 1 : STEP_RAW;
  localparam logic [2:0] CONFIRM_SCANS = 3'h4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CLEAR = 4'h1;
  localparam logic [3:0] REG_DISP_PTR = 4'h2;
  localparam logic [3:0] REG_DISP_A = 4'h3;
  localparam logic [3:0] REG_DISP_B = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_CHAR_LO = 4'h6;
  localparam logic [3:0] REG_CHAR_HI = 4'h7;
  localparam logic [3:0] REG_SCAN_POS = 4'h8;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ORG_BIT = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int unsigned CHAR_SHIFT_BIT = 6;
  localparam int unsigned CHAR_CTRL_BIT = 7;
  localparam logic [3:0] STATUS_OVERRUN = 4'hF;
  localparam logic [7:0] STROBE_RESET = 8'h01;
  localparam logic SCAN_FF_RESET = 1'b0;

  typedef enum logic [1:0] {MODE_SCAN_KEYS, MODE_ENCODED, MODE_SENSOR, MODE_SPARE} kbd_mode_t;

endpackage

/* store_if.sv */
// Write and read port of the shared 64-bit character and sensor store
`timescale 1ns/1ps
`default_nettype none
interface store_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;
  modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

/* char_store.sv */
// Eight-by-eight flip-flop store used as key FIFO or sensor map
`timescale 1ns/1ps
`default_nettype none
module char_store #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  store_if.store port
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  assign port.rd_data = mem_r[port.rd_idx];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (port.wr_en) begin
      mem_r[port.wr_idx] <= port.wr_data;
    end
  end
endmodule
`default_nettype wire

/* scan_sequencer.sv */
// Return and scan counters, rotating scan strobe and scan flip-flop
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer #(
  parameter int unsigned LINES = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_step,
  output logic [2:0] o_ret_idx,
  output logic [2:0] o_scan_idx,
  output logic [LINES-1:0] o_strobe,
  output logic o_scan_ff,
  output logic o_row_end,
  output logic o_pass_end
);
  assign o_row_end = i_step && (o_ret_idx == 3'h7);
  assign o_pass_end = o_row_end && (o_scan_idx == 3'h7);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_ret_idx <= '0;
      o_scan_idx <= '0;
      o_strobe <= kbd_pkg::STROBE_RESET;
      o_scan_ff <= kbd_pkg::SCAN_FF_RESET;
    end else if (i_step) begin
      o_ret_idx <= o_ret_idx + 3'h1;
      if (o_row_end) begin
        o_scan_idx <= o_scan_idx + 3'h1;
        o_strobe <= {o_strobe[LINES-2:0], o_strobe[LINES-1]};
      end
      if (o_pass_end) begin
        o_scan_ff <= ~o_scan_ff;
      end
    end
  end
endmodule
`default_nettype wire

/* keyboard_matrix_scanner.sv */
// Keyboard and sensor matrix scanner with key FIFO and display registers
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - Key pressed while accepted key held becomes a new press after release.
// - Key pressed and released while accepted key held is discarded.
// - Key code is scan index times eight plus return index, six bits.
// - Scan counter steps once per return counter wrap, both modulo 8.
// - Scanned keyboard closures are confirmed over about 11 ms.
// - Validated code enters the FIFO with shift and control samples.
// - One-hot scan strobe rotates from line 0 to 7 each scan step.
// - Scan flip-flop toggles every full pass, inactive after reset.
// - Scanned keyboard mode looks at one return line chosen by return counter.
// - Sensor mode stores all eight return lines per scan line, undebounced.
// - One 64-bit store serves as key FIFO or sensor map.
// - Encoded mode loads the return-line byte straight into the FIFO.
// - Timing from bus clocks, cycle start from sync, selection from bank line.
// - Four-bit data path carries commands, key data and display data.
// - Display storage is two 16x4 displays or one 32x4 display.
// - Register A drives the A outputs, register B the B outputs.
// - Outside sensor mode status gives characters held, 0 to 8, or 15 on overrun.
// - Four more passes after detection; accept if alone and still down.
// - Key event on entry; stays while overrun until a clear command.
// - A key validated with eight held is dropped and sets overrun.
module keyboard_matrix_scanner #(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned LINES = 8,
  parameter int unsigned STEP_CYCLES = kbd_pkg::STEP_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_phi1,
  input wire logic i_phi2,
  input wire logic i_sync,
  input wire logic i_memory_bank_select,
  input wire logic [3:0] i_addr,
  input wire logic [3:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [3:0] o_rdata,
  input wire logic [LINES-1:0] i_return_sense_lines,
  input wire logic i_shift,
  input wire logic i_control,
  output logic [LINES-1:0] o_scan_strobe_lines,
  output logic o_display_bank_select,
  output logic [3:0] o_disp_a_outputs,
  output logic [3:0] o_disp_b_outputs,
  output logic o_key_event
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] key_code(input logic [2:0] scan, input logic [2:0] ret);
    key_code = {scan, ret};
  endfunction

  function automatic logic [1:0] sat_add(input logic [1:0] a, input logic b);
    sat_add = (a == 2'h2) ? 2'h2 : a + {1'b0, b};
  endfunction

  typedef enum logic [1:0] {KS_IDLE, KS_CONFIRM, KS_HELD} key_state_t;

  localparam logic [3:0] FIFO_FULL = 4'(FIFO_DEPTH);
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

  // ----------------------------------------------------------------
  // Bus timing: one step per STEP_CYCLES instruction cycles
  // ----------------------------------------------------------------
  // Phase 1 only qualifies the phase 2 edge, so a glitch on phase 1 alone
  // cannot start a cycle.
  logic phi2_d_r;
  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic step_r;
  wire bus_edge = phi2_d_r && !i_phi2 && !i_phi1;
  wire cycle_tick = bus_edge && i_sync;
  wire div_wrap = cycle_tick && (div_r == STEP_LAST);

  assign div_nxt = div_wrap ? 8'h00 : (cycle_tick ? div_r + 8'h01 : div_r);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      phi2_d_r <= 1'b0;
      div_r <= 8'h00;
      step_r <= 1'b0;
    end else begin
      phi2_d_r <= i_phi2;
      div_r <= div_nxt;
      step_r <= div_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Scan counters and strobes
  // ----------------------------------------------------------------
  logic [2:0] ret_idx;
  logic [2:0] scan_idx;
  logic scan_ff;
  logic row_end;
  logic pass_end;

  scan_sequencer #(.LINES(LINES)) u_scan (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_step(step_r),
    .o_ret_idx(ret_idx),
    .o_scan_idx(scan_idx),
    .o_strobe(o_scan_strobe_lines),
    .o_scan_ff(scan_ff),
    .o_row_end(row_end),
    .o_pass_end(pass_end)
  );

  assign o_display_bank_select = scan_ff;

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic [3:0] ctrl_r;
  wire acc_wr = i_wr && i_memory_bank_select;
  wire acc_rd = i_rd && i_memory_bank_select;
  wire wr_ctrl = acc_wr && (i_addr == kbd_pkg::REG_CTRL);
  wire wr_clear = acc_wr && (i_addr == kbd_pkg::REG_CLEAR);
  wire wr_ptr = acc_wr && (i_addr == kbd_pkg::REG_DISP_PTR);
  wire wr_da = acc_wr && (i_addr == kbd_pkg::REG_DISP_A);
  wire wr_db = acc_wr && (i_addr == kbd_pkg::REG_DISP_B);
  wire rd_hi = acc_rd && (i_addr == kbd_pkg::REG_CHAR_HI);
  wire [1:0] mode = ctrl_r[kbd_pkg::CTRL_MODE_LSB +: 2];
  wire org32 = ctrl_r[kbd_pkg::CTRL_ORG_BIT];
  wire m_keys = (mode == kbd_pkg::MODE_SCAN_KEYS);
  wire m_enc = (mode == kbd_pkg::MODE_ENCODED);
  wire m_sens = (mode == kbd_pkg::MODE_SENSOR);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= kbd_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Scanned keyboard: per-pass sampling
  // ----------------------------------------------------------------
  key_state_t ks_r;
  logic [5:0] cand_r;
  logic [5:0] acc_code_r;
  logic [2:0] passes_r;
  logic [1:0] hits_r;
  logic [5:0] hit_code_r;
  logic cand_seen_r;
  logic acc_seen_r;
  wire hit = step_r && i_return_sense_lines[ret_idx];
  wire [5:0] pos_code = key_code(scan_idx, ret_idx);
  wire [1:0] hits_now = sat_add(hits_r, hit);
  wire [5:0] code_now = (hit && hits_r == 2'h0) ? pos_code : hit_code_r;
  wire cand_now = cand_seen_r || (hit && pos_code == cand_r);
  wire acc_now = acc_seen_r || (hit && pos_code == acc_code_r);
  wire confirm_done = (ks_r == KS_CONFIRM) && (passes_r == kbd_pkg::CONFIRM_SCANS - 3'h1);
  // Accept only when the original key is the single key down in the last pass
  wire key_valid = pass_end && m_keys && confirm_done && cand_now && (hits_now == 2'h1);
  wire [7:0] key_char = {i_control, i_shift, cand_r};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      hits_r <= 2'h0;
      hit_code_r <= 6'h00;
      cand_seen_r <= 1'b0;
      acc_seen_r <= 1'b0;
    end else if (pass_end || !m_keys) begin
      hits_r <= 2'h0;
      hit_code_r <= 6'h00;
      cand_seen_r <= 1'b0;
      acc_seen_r <= 1'b0;
    end else if (step_r) begin
      hits_r <= hits_now;
      hit_code_r <= code_now;
      cand_seen_r <= cand_now;
      acc_seen_r <= acc_now;
    end
  end

  // ----------------------------------------------------------------
  // Debounce and two-key rollover
  // ----------------------------------------------------------------
  // Decisions are taken only at pass boundaries, so bounce inside a pass
  // merely looks like a key that is still down or already gone.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ks_r <= KS_IDLE;
      cand_r <= 6'h00;
      acc_code_r <= 6'h00;
      passes_r <= 3'h0;
    end else if (!m_keys) begin
      ks_r <= KS_IDLE;
    end else if (pass_end) begin
      case (ks_r)
        KS_IDLE: begin
          // Simultaneous closures wait until only one key remains
          if (hits_now == 2'h1) begin
            cand_r <= code_now;
            passes_r <= 3'h0;
            ks_r <= KS_CONFIRM;
          end
        end
        KS_CONFIRM: begin
          passes_r <= passes_r + 3'h1;
          if (confirm_done) begin
            if (key_valid) begin
              acc_code_r <= cand_r;
              ks_r <= KS_HELD;
            end else begin
              ks_r <= KS_IDLE;
            end
          end
        end
        KS_HELD: begin
          if (!acc_now) begin
            // Held second key restarts as an original press; a released one is gone
            if (hits_now == 2'h1) begin
              cand_r <= code_now;
              passes_r <= 3'h0;
              ks_r <= KS_CONFIRM;
            end else begin
              ks_r <= KS_IDLE;
            end
          end
        end
        default: begin
          ks_r <= KS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Encoded keyboard
  // ----------------------------------------------------------------
  // A byte is taken once per change to a non-zero value; a key held down
  // therefore enters only once.
  logic [7:0] enc_prev_r;
  wire enc_load = step_r && m_enc && (i_return_sense_lines != enc_prev_r)
                  && (i_return_sense_lines != 8'h00);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      enc_prev_r <= 8'h00;
    end else if (step_r) begin
      enc_prev_r <= i_return_sense_lines;
    end
  end

  // ----------------------------------------------------------------
  // Key FIFO and sensor map
  // ----------------------------------------------------------------
  store_if st ();

  char_store #(.DEPTH(FIFO_DEPTH), .WIDTH(8)) u_store (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .port(st)
  );

  logic [2:0] wr_ptr_r;
  logic [2:0] rd_ptr_r;
  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic overrun_r;
  logic overrun_nxt;
  logic sensor_any_r;
  logic sensor_pass_r;
  wire push_req = key_valid || enc_load;
  wire [7:0] push_data = m_enc ? i_return_sense_lines : key_char;
  wire fifo_full = (count_r == FIFO_FULL);
  wire push_ok = push_req && !fifo_full;
  wire pop = rd_hi && !m_sens && (count_r != 4'h0);
  wire ptr_step = m_sens ? rd_hi : pop;

  assign st.wr_en = m_sens ? row_end : push_ok;
  assign st.wr_idx = m_sens ? scan_idx : wr_ptr_r;
  assign st.wr_data = m_sens ? i_return_sense_lines : push_data;
  assign st.rd_idx = rd_ptr_r;
  assign count_nxt = count_r + {3'h0, push_ok} - {3'h0, pop};
  // A drop in the same cycle as a clear keeps the overrun
  assign overrun_nxt = (push_req && fifo_full) || (overrun_r && !wr_clear);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      count_r <= 4'h0;
      overrun_r <= 1'b0;
    end else if (wr_ctrl) begin
      // A mode change reuses the store, so old contents are abandoned
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      count_r <= 4'h0;
      overrun_r <= 1'b0;
    end else begin
      if (push_ok) begin
        wr_ptr_r <= wr_ptr_r + 3'h1;
      end
      if (ptr_step) begin
        rd_ptr_r <= rd_ptr_r + 3'h1;
      end
      count_r <= count_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  // Sensor hits are collected over a pass and reported for the whole next one
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sensor_any_r <= 1'b0;
      sensor_pass_r <= 1'b0;
    end else if (!m_sens) begin
      sensor_any_r <= 1'b0;
      sensor_pass_r <= 1'b0;
    end else if (pass_end) begin
      sensor_any_r <= sensor_pass_r || (i_return_sense_lines != 8'h00);
      sensor_pass_r <= 1'b0;
    end else if (row_end && i_return_sense_lines != 8'h00) begin
      sensor_pass_r <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_key_event <= 1'b0;
    end else if (m_sens) begin
      o_key_event <= sensor_any_r;
    end else begin
      o_key_event <= (count_nxt != 4'h0) || overrun_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Display registers
  // ----------------------------------------------------------------
  logic [3:0] disp_a_r [16];
  logic [3:0] disp_b_r [16];
  logic [4:0] dptr_r;
  wire dwr = wr_da || wr_db;
  // One 32-digit display fills A then B through a single pointer
  wire to_b = org32 ? dptr_r[4] : wr_db;
  wire [4:0] dptr_inc = dptr_r + 5'h01;
  wire [4:0] dptr_nxt = org32 ? dptr_inc : {1'b0, dptr_inc[3:0]};
  wire [3:0] digit = {scan_ff, scan_idx};

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dptr_r <= 5'h00;
      for (int i = 0; i < 16; i++) begin
        disp_a_r[i] <= 4'h0;
        disp_b_r[i] <= 4'h0;
      end
    end else if (wr_ptr) begin
      dptr_r <= {1'b0, i_wdata};
    end else if (dwr) begin
      if (to_b) begin
        disp_b_r[dptr_r[3:0]] <= i_wdata;
      end else begin
        disp_a_r[dptr_r[3:0]] <= i_wdata;
      end
      dptr_r <= dptr_nxt;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_disp_a_outputs <= 4'h0;
      o_disp_b_outputs <= 4'h0;
    end else begin
      o_disp_a_outputs <= disp_a_r[digit];
      o_disp_b_outputs <= disp_b_r[digit];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [3:0] status = m_sens ? {3'h0, sensor_any_r} : (overrun_r ? kbd_pkg::STATUS_OVERRUN : count_r);
  logic [3:0] rsel;

  always_comb begin
    case (i_addr)
      kbd_pkg::REG_CTRL: rsel = ctrl_r;
      kbd_pkg::REG_DISP_PTR: rsel = dptr_r[3:0];
      kbd_pkg::REG_STATUS: rsel = status;
      kbd_pkg::REG_CHAR_LO: rsel = st.rd_data[3:0];
      kbd_pkg::REG_CHAR_HI: rsel = st.rd_data[7:4];
      kbd_pkg::REG_SCAN_POS: rsel = {scan_ff, scan_idx};
      default: rsel = 4'h0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 4'h0;
    end else if (acc_rd) begin
      o_rdata <= rsel;
    end else begin
      o_rdata <= 4'h0;
    end
  end

endmodule
`default_nettype wire

/* bus_timing_model.sv */
// Processor-side bus timing source: two-phase clocks and cycle sync
`timescale 1ns/1ps
`default_nettype none
module bus_timing_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  output logic o_phi1,
  output logic o_phi2,
  output logic o_sync
);
  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  // Eight system clocks per bus period keeps the two phases apart
  logic [2:0] cnt_r;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 3'h0;
      o_phi1 <= 1'b0;
      o_phi2 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      o_phi1 <= (cnt_r == 3'h7) || (cnt_r == 3'h0);
      o_phi2 <= (cnt_r == 3'h3) || (cnt_r == 3'h4);
      o_sync <= cnt_r[2] || (cnt_r == 3'h3);
    end
  end
endmodule
`default_nettype wire

/* kbd_asserts.sv */
// Port-level checker for the keyboard matrix scanner
`timescale 1ns/1ps
`default_nettype none
module kbd_asserts (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_memory_bank_select,
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  input wire logic [3:0] o_rdata,
  input wire logic [7:0] o_scan_strobe_lines,
  input wire logic o_display_bank_select,
  input wire logic o_key_event
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [7:0] s;
  assign s = o_scan_strobe_lines;
  strobe_onehot_a: assert property ($onehot(s)) else $error("strobe not one-hot");
  strobe_rotate_a: assert property (!$stable(s) |-> s == {$past(s[6:0]), $past(s[7])})
    else $error("strobe did not rotate by one");
  wrap_toggles_a: assert property ($past(s) == 8'h80 && s == 8'h01 |-> $changed(o_display_bank_select))
    else $error("scan flip-flop missed a toggle");
  toggle_on_wrap_a: assert property ($changed(o_display_bank_select) |-> $past(s) == 8'h80 && s == 8'h01)
    else $error("scan flip-flop toggled mid pass");
  idle_rdata_a: assert property (!$past(i_rd) |-> o_rdata == 4'h0) else $error("read data outside window");
  deselect_zero_a: assert property ($past(i_rd) && !$past(i_memory_bank_select) |-> o_rdata == 4'h0)
    else $error("deselected read returned data");
  status_range_a: assert property ($past(i_rd) && $past(i_memory_bank_select) && $past(i_addr) == kbd_pkg::REG_STATUS
    |-> o_rdata <= 4'h8 || o_rdata == kbd_pkg::STATUS_OVERRUN) else $error("status out of range");
  unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) > 4'h8 |-> o_rdata == 4'h0)
    else $error("unmapped read returned data");
  scan_pos_a: assert property ($past(i_rd) && $past(i_memory_bank_select) && $past(i_addr) == kbd_pkg::REG_SCAN_POS
    |-> $past(s) == (8'h01 << o_rdata[2:0]) && o_rdata[3] == $past(o_display_bank_select))
    else $error("scan position mismatch");
  key_cov: cover property ($rose(o_key_event));
  wrap_cov: cover property ($changed(o_display_bank_select));
  overrun_cov: cover property ($past(i_rd) && $past(i_addr) == kbd_pkg::REG_STATUS && o_rdata == 4'hF);
endmodule
bind keyboard_matrix_scanner kbd_asserts kbd_asserts_i (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_memory_bank_select(i_memory_bank_select), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_scan_strobe_lines(o_scan_strobe_lines), .o_display_bank_select(o_display_bank_select), .o_key_event(o_key_event));
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the keyboard matrix scanner
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_mclk = 0, i_rst = 1, phi1, phi2, sync, i_memory_bank_select = 1, i_wr = 0, i_rd = 0;
  logic i_shift = 0, i_control = 0, o_display_bank_select, o_key_event;
  logic [3:0] i_addr = 0, i_wdata = 0, o_rdata, o_disp_a_outputs, o_disp_b_outputs, v;
  logic [7:0] ret = 0, enc = 0, o_scan_strobe_lines, c;
  logic [7:0] rows [8] = '{default: 8'h00};
  int err_count = 0, n_checks = 0, cyc = 0;
  always #5 i_mclk = ~i_mclk;
  bus_timing_model bus_timing_model_i (.i_mclk(i_mclk), .i_rst(i_rst), .o_phi1(phi1), .o_phi2(phi2), .o_sync(sync));
  keyboard_matrix_scanner #(.STEP_CYCLES(1)) keyboard_matrix_scanner_i (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_phi1(phi1), .i_phi2(phi2), .i_sync(sync), .i_memory_bank_select(i_memory_bank_select), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_return_sense_lines(ret), .i_shift(i_shift),
    .i_control(i_control), .o_scan_strobe_lines(o_scan_strobe_lines), .o_display_bank_select(o_display_bank_select),
    .o_disp_a_outputs(o_disp_a_outputs), .o_disp_b_outputs(o_disp_b_outputs), .o_key_event(o_key_event));
  // ----------------------------------------------------------------
  // Key matrix: a closed key joins its strobe to its return line
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    logic [7:0] t;
    t = enc;
    for (int j = 0; j < 8; j++) if (o_scan_strobe_lines[j]) t = t | rows[j];
    ret <= t;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      final_report;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge i_mclk);
    i_addr <= a; i_wdata <= d; i_wr <= 1;
    @(posedge i_mclk);
    i_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [3:0] d);
    @(posedge i_mclk);
    i_addr <= a; i_rd <= 1;
    @(posedge i_mclk);
    i_rd <= 0;
    #1 d = o_rdata;
  endtask
  task automatic rd_char(output logic [7:0] ch);
    logic [3:0] lo, hi;
    rd(kbd_pkg::REG_CHAR_LO, lo);
    rd(kbd_pkg::REG_CHAR_HI, hi);
    ch = {hi, lo};
  endtask
  task automatic wait_ev;
    int k;
    k = 0;
    while (o_key_event !== 1'b1 && k < 6000) begin
      @(posedge i_mclk);
      k++;
    end
    check("key_event", {7'h0, o_key_event}, 8'h01);
  endtask
  task automatic hold(input int s, input logic [7:0] r, input int n);
    @(posedge i_mclk) rows[s] <= r;
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("strobe", o_scan_strobe_lines, kbd_pkg::STROBE_RESET);
    check("scan_ff", {7'h0, o_display_bank_select}, 8'h00);
    rd(kbd_pkg::REG_STATUS, v);
    check("status", v, 8'h00);
    rd(4'hF, v);
    check("unmapped", v, 8'h00);
    @(posedge i_mclk) i_memory_bank_select <= 0;
    rd(kbd_pkg::REG_STATUS, v);
    check("desel", v, 8'h00);
    @(posedge i_mclk) i_memory_bank_select <= 1;
    rd(kbd_pkg::REG_SCAN_POS, v);
  endtask
  task automatic t_display;
    int k;
    wr(kbd_pkg::REG_CTRL, 4'h4);
    wr(kbd_pkg::REG_DISP_PTR, 4'h0);
    wr(kbd_pkg::REG_DISP_A, 4'h5);
    wr(kbd_pkg::REG_DISP_PTR, 4'hF);
    wr(kbd_pkg::REG_DISP_A, 4'h3);
    wr(kbd_pkg::REG_DISP_B, 4'hA);
    k = 0;
    while (!(o_scan_strobe_lines === 8'h01 && o_display_bank_select === 1'b0) && k < 2000) begin
      @(posedge i_mclk);
      k++;
    end
    repeat (4) @(posedge i_mclk);
    check("disp_a", {4'h0, o_disp_a_outputs}, 8'h05);
    check("disp_b", {4'h0, o_disp_b_outputs}, 8'h0A);
  endtask
  task automatic t_single;
    @(posedge i_mclk) i_shift <= 1;
    hold(5, 8'h08, 1);
    wait_ev;
    rd(kbd_pkg::REG_STATUS, v);
    check("status", v, 8'h01);
    rd_char(c);
    check("char", c, 8'h6B);
    hold(5, 8'h00, 1500);
    check("key_event", {7'h0, o_key_event}, 8'h00);
    @(posedge i_mclk) i_shift <= 0;
  endtask
  task automatic t_roll_new;
    hold(0, 8'h02, 1);
    wait_ev;
    rd_char(c);
    check("char", c, 8'h01);
    @(posedge i_mclk) i_control <= 1;
    hold(7, 8'h40, 4000);
    rd(kbd_pkg::REG_STATUS, v);
    check("status", v, 8'h00);
    hold(0, 8'h00, 1);
    wait_ev;
    rd_char(c);
    check("char", c, 8'hBE);
    hold(7, 8'h00, 1500);
    @(posedge i_mclk) i_control <= 0;
  endtask
  task automatic t_roll_drop;
    hold(1, 8'h04, 1);
    wait_ev;
    rd_char(c);
    check("char", c, 8'h0A);
    hold(3, 8'h08, 600);
    hold(3, 8'h00, 3000);
    hold(1, 8'h00, 3000);
    rd(kbd_pkg::REG_STATUS, v);
    check("status", v, 8'h00);
  endtask
  task automatic t_overrun;
    for (int i = 0; i < 9; i++) begin
      hold(2 + i / 8, 8'h01 << (i % 8), 3500);
      hold(2 + i / 8, 8'h00, 1200);
    end
    rd(kbd_pkg::REG_STATUS, v);
    check("status", v, 8'h0F);
    for (int i = 0; i < 8; i++) begin
      rd_char(c);
      check("char", c, 8'h10 + i);
    end
    check("key_event", {7'h0, o_key_event}, 8'h01);
    wr(kbd_pkg::REG_CLEAR, 4'h0);
    repeat (3) @(posedge i_mclk);
    check("key_event", {7'h0, o_key_event}, 8'h00);
  endtask
  task automatic t_modes;
    wr(kbd_pkg::REG_CTRL, 4'h1);
    @(posedge i_mclk) enc <= 8'hA5;
    wait_ev;
    rd_char(c);
    check("char", c, 8'hA5);
    @(posedge i_mclk) enc <= 8'h00;
    wr(kbd_pkg::REG_CTRL, 4'h2);
    hold(2, 8'h90, 1500);
    rd(kbd_pkg::REG_STATUS, v);
    check("status", v, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rd_char(c);
      check("sensor_row", c, (i == 2) ? 8'h90 : 8'h00);
    end
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst <= 0;
    @(posedge i_mclk);
    t_reset;
    t_display;
    t_single;
    t_roll_new;
    t_roll_drop;
    t_overrun;
    t_modes;
    final_report;
  end
endmodule
`default_nettype wire
